/* rtl/ldc_pkg.sv */
// Shared constants and types for the laser driver control register bank
package ldc_pkg;

   // ****************************************
   // Serial slave address and byte framing
   // ****************************************
   localparam logic [6:0] LDC_SLAVE_ADDR = 7'h08;
   localparam logic [3:0] LDC_BYTE_BITS  = 4'h8;
   localparam logic [7:0] LDC_RESET_VAL  = 8'h00;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] LDC_REG_MAIN  = 8'h00;
   localparam logic [7:0] LDC_REG_AUX   = 8'h01;
   localparam logic [7:0] LDC_REG_MODL  = 8'h02;
   localparam logic [7:0] LDC_REG_MODH  = 8'h03;
   localparam logic [7:0] LDC_REG_BIASL = 8'h04;
   localparam logic [7:0] LDC_REG_BIASH = 8'h05;
   localparam logic [7:0] LDC_REG_EQ    = 8'h06;
   localparam logic [7:0] LDC_REG_CP    = 8'h07;
   localparam logic [7:0] LDC_REG_LIM   = 8'h08;
   localparam logic [7:0] LDC_REG_HCE   = 8'h09;
   localparam int         LDC_NUM_REGS  = 10;

   // ****************************************
   // Writable bits of each register
   // ****************************************
   localparam logic [7:0] LDC_MASK_MAIN = 8'hFF;
   localparam logic [7:0] LDC_MASK_AUX  = 8'h0F;
   localparam logic [7:0] LDC_MASK_LSB2 = 8'h03;
   localparam logic [7:0] LDC_MASK_FULL = 8'hFF;
   localparam logic [7:0] LDC_MASK_LIM  = 8'h0F;
   localparam logic [7:0] LDC_MASK_HCE  = 8'h01;
   localparam logic [7:0] LDC_MASK_NONE = 8'h00;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int LDC_MAIN_CHIP_ON   = 7;
   localparam int LDC_MAIN_RANGE_HI  = 6;
   localparam int LDC_MAIN_RANGE_LO  = 5;
   localparam int LDC_MAIN_OPEN_LOOP = 4;
   localparam int LDC_MAIN_FAULT_DET = 3;
   localparam int LDC_MAIN_SWAP      = 2;
   localparam int LDC_MAIN_EQ_ON     = 1;
   localparam int LDC_MAIN_PD_ORIENT = 0;
   localparam int LDC_AUX_OFFSET_OFF = 3;
   localparam int LDC_AUX_BIAS_DIR   = 2;
   localparam int LDC_AUX_CP_RANGE_H = 1;
   localparam int LDC_CP_SIGN        = 7;
   localparam int LDC_LIM_SIGN       = 3;
   localparam int LDC_LIM_MAG_H      = 2;
   localparam int LDC_HCE_ON         = 0;
   localparam int LDC_LSB_H          = 1;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      LDC_PD_SMALL,
      LDC_PD_MID,
      LDC_PD_LARGE
   } ldc_pd_range_t;

   typedef struct packed {
      logic [9:0] mod_current_code;
      logic [9:0] bias_current_code;
      logic [7:0] equalizer_level;
      logic       crossing_shift_sign;
      logic [6:0] crossing_shift_magnitude;
      logic       limiter_bias_sign;
      logic [2:0] limiter_bias_magnitude;
      logic       high_mod_current_on;
      logic [1:0] crossing_range;
   } ldc_settings_t;

   typedef struct packed {
      logic          chip_active;
      logic          open_loop_select;
      logic          output_swap;
      logic          equalizer_on;
      logic          photodiode_orientation;
      logic          offset_cancel_on;
      logic          crossing_adjust_on;
      logic          bias_source;
      logic          bias_sink;
      logic          fault_detect_live;
      ldc_pd_range_t photodiode_range;
   } ldc_mode_t;

endpackage

/* rtl/ldc_mode.sv */
// Mode decode and fault latch behind the main and auxiliary control registers
`timescale 1ns/100ps
`default_nettype none
module ldc_mode (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // Control register contents
   input  wire logic [7:0]        main_ctrl,
   input  wire logic [7:0]        aux_ctrl,
   // Chip pins
   input  wire logic              disable_pin,
   input  wire logic              fault_event,
   // Decoded state
   output ldc_pkg::ldc_mode_t     mode,
   output logic                   fault_latched
);
   import ldc_pkg::*;

   logic chip_on_q;
   logic fault_q;
   logic detect_live;
   logic fault_clear;

   // ****************************************
   // Fault latch
   // ****************************************
   // Pin disable keeps the registers; only reset or the bit toggle clears the fault
   assign detect_live = main_ctrl[LDC_MAIN_FAULT_DET];
   assign fault_clear = main_ctrl[LDC_MAIN_CHIP_ON] & ~chip_on_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chip_on_q <= 1'b0;
      end else if (ce) begin
         chip_on_q <= main_ctrl[LDC_MAIN_CHIP_ON];
      end
   end

   // A fault arriving in the clearing cycle wins over the clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_q <= 1'b0;
      end else if (ce) begin
         if (detect_live && fault_event) begin
            fault_q <= 1'b1;
         end else if (fault_clear) begin
            fault_q <= 1'b0;
         end
      end
   end

   assign fault_latched = fault_q;

   // ****************************************
   // Mode decode
   // ****************************************
   always_comb begin
      mode.chip_active = main_ctrl[LDC_MAIN_CHIP_ON] & ~disable_pin;
      mode.open_loop_select = main_ctrl[LDC_MAIN_OPEN_LOOP];
      mode.output_swap = main_ctrl[LDC_MAIN_SWAP];
      mode.equalizer_on = main_ctrl[LDC_MAIN_EQ_ON];
      mode.photodiode_orientation = main_ctrl[LDC_MAIN_PD_ORIENT];
      mode.offset_cancel_on = ~aux_ctrl[LDC_AUX_OFFSET_OFF];
      mode.crossing_adjust_on = aux_ctrl[LDC_AUX_OFFSET_OFF];
      mode.bias_source = aux_ctrl[LDC_AUX_BIAS_DIR];
      mode.bias_sink = ~aux_ctrl[LDC_AUX_BIAS_DIR];
      mode.fault_detect_live = detect_live;
      if (main_ctrl[LDC_MAIN_RANGE_HI]) begin
         mode.photodiode_range = LDC_PD_LARGE;
      end else if (main_ctrl[LDC_MAIN_RANGE_LO]) begin
         mode.photodiode_range = LDC_PD_MID;
      end else begin
         mode.photodiode_range = LDC_PD_SMALL;
      end
   end

endmodule // ldc_mode
`default_nettype wire

/* rtl/ldc_regs.sv */
// Laser driver control register bank with its two-wire serial slave
// What this block does
// - Hold 10-bit modulation code, two low bits at 0x02, upper eight at 0x03.
// - Hold 10-bit bias code, two low bits at 0x04, upper eight at 0x05.
// - Hold 8-bit equalizer level in all of register 0x06.
// - Register 0x07 holds crossing shift sign in bit 7, magnitude in 6:0.
// - Register 0x08 holds limiter sign in bit 3, magnitude in 2:0.
// - Register 0x09 bit 0 enables high modulation current.
// - Main control bit 7 turns the chip on when set.
// - Toggling the chip-on bit low then high clears a latched fault.
// - Range field 1X largest, 01 middle, 00 smallest photodiode range.
// - Main bit 4 selects open loop; clear selects the power loop.
// - Faults are detected only while main bit 3 is set.
// - Main bit 2 swaps the positive and negative output pairs.
// - Main bit 1 turns the input equalizer on.
// - Main bit 0 set means cathode to supply, clear anode to ground.
// - Aux bit 3 disables offset cancel and enables crossing adjust.
// - Aux bit 2 set makes the bias output source current.
// - Aux bit 2 clear makes the bias output sink current.
// - Every register clears to zero at reset.
// - Disabling keeps all registers; re-enabling resumes prior settings.
// - Access is slave address, direction, register address, one data byte.
`timescale 1ns/100ps
`default_nettype none
module ldc_regs (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // Two-wire serial pins
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   // Chip pins
   input  wire logic              disable_pin,
   input  wire logic              fault_event,
   // Settings to the analog blocks
   output ldc_pkg::ldc_settings_t settings,
   output ldc_pkg::ldc_mode_t     mode,
   output logic                   fault_latched,
   output logic                   write_strobe
);
   import ldc_pkg::*;

   typedef enum logic [3:0] {
      LDC_IDLE,
      LDC_ADDR,
      LDC_ACK_ADDR,
      LDC_REG,
      LDC_ACK_REG,
      LDC_WDATA,
      LDC_ACK_DATA,
      LDC_RDATA,
      LDC_RACK,
      LDC_WAIT
   } ldc_state_t;

   // ****************************************
   // Decode helpers
   // ****************************************
   // Writable bits of a register; unmapped offsets have none
   function automatic logic [7:0] ldc_wmask(input logic [7:0] addr);
      case (addr)
         LDC_REG_MAIN:  ldc_wmask = LDC_MASK_MAIN;
         LDC_REG_AUX:   ldc_wmask = LDC_MASK_AUX;
         LDC_REG_MODL:  ldc_wmask = LDC_MASK_LSB2;
         LDC_REG_MODH:  ldc_wmask = LDC_MASK_FULL;
         LDC_REG_BIASL: ldc_wmask = LDC_MASK_LSB2;
         LDC_REG_BIASH: ldc_wmask = LDC_MASK_FULL;
         LDC_REG_EQ:    ldc_wmask = LDC_MASK_FULL;
         LDC_REG_CP:    ldc_wmask = LDC_MASK_FULL;
         LDC_REG_LIM:   ldc_wmask = LDC_MASK_LIM;
         LDC_REG_HCE:   ldc_wmask = LDC_MASK_HCE;
         default:       ldc_wmask = LDC_MASK_NONE;
      endcase
   endfunction

   function automatic logic ldc_mapped(input logic [7:0] addr);
      ldc_mapped = (addr < 8'(LDC_NUM_REGS));
   endfunction

   // ****************************************
   // Storage and serial state
   // ****************************************
   logic [7:0]  regs_q [LDC_NUM_REGS];
   ldc_state_t  state_q;
   logic [3:0]  bit_cnt_q;
   logic [7:0]  shift_q;
   logic [7:0]  tx_q;
   logic [7:0]  reg_ptr_q;
   logic        read_q;
   logic        drive_low_q;
   logic        wr_pulse_q;
   logic        scl_q;
   logic        sda_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_seen;
   logic        stop_seen;
   logic [7:0]  rd_data;
   logic [3:0]  ptr_idx;

   // ****************************************
   // Line events
   // ****************************************
   // Pins arrive synchronous to clk, so edges come from one history stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (ce) begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   assign scl_rise   = scl_in & ~scl_q;
   assign scl_fall   = ~scl_in & scl_q;
   assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;

   assign ptr_idx = reg_ptr_q[3:0];
   assign rd_data = ldc_mapped(reg_ptr_q) ? regs_q[ptr_idx] : LDC_RESET_VAL;

   // ****************************************
   // Serial slave sequencer
   // ****************************************
   // One data byte per transfer; later bytes are left unacknowledged
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q     <= LDC_IDLE;
         bit_cnt_q   <= '0;
         shift_q     <= LDC_RESET_VAL;
         tx_q        <= LDC_RESET_VAL;
         reg_ptr_q   <= LDC_RESET_VAL;
         read_q      <= 1'b0;
         drive_low_q <= 1'b0;
         wr_pulse_q  <= 1'b0;
      end else if (ce) begin
         wr_pulse_q <= 1'b0;
         if (start_seen) begin
            state_q     <= LDC_ADDR;
            bit_cnt_q   <= '0;
            drive_low_q <= 1'b0;
         end else if (stop_seen) begin
            state_q     <= LDC_IDLE;
            drive_low_q <= 1'b0;
         end else begin
            case (state_q)
               LDC_ADDR, LDC_REG, LDC_WDATA: begin
                  if (scl_rise) begin
                     shift_q   <= {shift_q[6:0], sda_in};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (scl_fall && bit_cnt_q == LDC_BYTE_BITS) begin
                     bit_cnt_q <= '0;
                     if (state_q == LDC_ADDR) begin
                        // Foreign address: leave the line high and wait
                        if (shift_q[7:1] == LDC_SLAVE_ADDR) begin
                           read_q      <= shift_q[0];
                           drive_low_q <= 1'b1;
                           state_q     <= LDC_ACK_ADDR;
                        end else begin
                           state_q <= LDC_WAIT;
                        end
                     end else if (state_q == LDC_REG) begin
                        reg_ptr_q   <= shift_q;
                        drive_low_q <= 1'b1;
                        state_q     <= LDC_ACK_REG;
                     end else begin
                        wr_pulse_q  <= 1'b1;
                        drive_low_q <= 1'b1;
                        state_q     <= LDC_ACK_DATA;
                     end
                  end
               end
               LDC_ACK_ADDR: begin
                  if (scl_fall) begin
                     drive_low_q <= 1'b0;
                     state_q     <= LDC_REG;
                  end
               end
               LDC_ACK_REG: begin
                  if (scl_fall) begin
                     if (read_q) begin
                        tx_q        <= rd_data;
                        drive_low_q <= ~rd_data[7];
                        state_q     <= LDC_RDATA;
                     end else begin
                        drive_low_q <= 1'b0;
                        state_q     <= LDC_WDATA;
                     end
                  end
               end
               LDC_ACK_DATA: begin
                  if (scl_fall) begin
                     drive_low_q <= 1'b0;
                     state_q     <= LDC_WAIT;
                  end
               end
               LDC_RDATA: begin
                  if (scl_rise) begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt_q == LDC_BYTE_BITS) begin
                        bit_cnt_q   <= '0;
                        drive_low_q <= 1'b0;
                        state_q     <= LDC_RACK;
                     end else begin
                        tx_q        <= {tx_q[6:0], 1'b0};
                        drive_low_q <= ~tx_q[6];
                     end
                  end
               end
               LDC_RACK: begin
                  // Master answer is not needed: one byte only
                  if (scl_fall) begin
                     state_q <= LDC_WAIT;
                  end
               end
               LDC_IDLE, LDC_WAIT: begin
                  drive_low_q <= 1'b0;
               end
               default: begin
                  state_q     <= LDC_IDLE;
                  drive_low_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   // Registers only clear at reset; disabling the chip leaves them alone
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < LDC_NUM_REGS; i++) begin
            regs_q[i] <= LDC_RESET_VAL;
         end
      end else if (ce) begin
         if (wr_pulse_q && ldc_mapped(reg_ptr_q)) begin
            regs_q[ptr_idx] <= shift_q & ldc_wmask(reg_ptr_q);
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Open-drain: only ever pull low
   assign sda_out      = 1'b0;
   assign sda_oe       = drive_low_q;
   assign write_strobe = wr_pulse_q;

   always_comb begin
      settings.mod_current_code = {regs_q[LDC_REG_MODH[3:0]],
                                   regs_q[LDC_REG_MODL[3:0]][LDC_LSB_H:0]};
      settings.bias_current_code = {regs_q[LDC_REG_BIASH[3:0]],
                                    regs_q[LDC_REG_BIASL[3:0]][LDC_LSB_H:0]};
      settings.equalizer_level = regs_q[LDC_REG_EQ[3:0]];
      settings.crossing_shift_sign = regs_q[LDC_REG_CP[3:0]][LDC_CP_SIGN];
      settings.crossing_shift_magnitude = regs_q[LDC_REG_CP[3:0]][LDC_CP_SIGN-1:0];
      settings.limiter_bias_sign = regs_q[LDC_REG_LIM[3:0]][LDC_LIM_SIGN];
      settings.limiter_bias_magnitude = regs_q[LDC_REG_LIM[3:0]][LDC_LIM_MAG_H:0];
      settings.high_mod_current_on = regs_q[LDC_REG_HCE[3:0]][LDC_HCE_ON];
      settings.crossing_range = regs_q[LDC_REG_AUX[3:0]][LDC_AUX_CP_RANGE_H:0];
   end

   ldc_mode u_mode (
      .clk           (clk),
      .rst           (rst),
      .ce            (ce),
      .main_ctrl     (regs_q[LDC_REG_MAIN[3:0]]),
      .aux_ctrl      (regs_q[LDC_REG_AUX[3:0]]),
      .disable_pin   (disable_pin),
      .fault_event   (fault_event),
      .mode          (mode),
      .fault_latched (fault_latched)
   );

endmodule // ldc_regs
`default_nettype wire

/* test/ldc_regs_assertions.sv */
// Port checks for the laser driver control register bank
`timescale 1ns/100ps
`default_nettype none
module ldc_regs_chk (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   ce,
   // Serial pins
   input  wire logic                   scl_in,
   input  wire logic                   sda_in,
   input  wire logic                   sda_out,
   input  wire logic                   sda_oe,
   // Chip pins and decoded state
   input  wire logic                   disable_pin,
   input  wire logic                   fault_event,
   input  wire ldc_pkg::ldc_settings_t settings,
   input  wire ldc_pkg::ldc_mode_t     mode,
   input  wire logic                   fault_latched,
   input  wire logic                   write_strobe
);
   import ldc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_sda_never_high: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data line moved while clock high");
   a_strobe_with_ack: assert property (write_strobe |-> sda_oe ##1 !write_strobe)
      else $error("write pulse without acknowledge or too long");
   a_settings_hold: assert property (!$past(write_strobe) |-> $stable(settings))
      else $error("settings changed without a write");
   a_disable_off: assert property (disable_pin |-> !mode.chip_active)
      else $error("chip active while disable pin high");
   a_offset_pair: assert property (mode.offset_cancel_on != mode.crossing_adjust_on)
      else $error("offset cancel and crossing adjust disagree");
   a_bias_pair: assert property (mode.bias_source != mode.bias_sink)
      else $error("bias direction outputs disagree");
   a_range_legal: assert property (mode.photodiode_range != ldc_pd_range_t'(2'b11))
      else $error("illegal photodiode range");
   a_fault_set: assert property ($rose(fault_latched) |-> $past(fault_event) && $past(mode.fault_detect_live))
      else $error("fault latched without enabled fault");
   a_fault_clear: assert property ($fell(fault_latched) |-> $past(write_strobe, 2) || $past(write_strobe, 3))
      else $error("fault cleared without a control write");
   a_fault_sticky: assert property (fault_latched && !write_strobe && !$past(write_strobe) |=> fault_latched)
      else $error("fault dropped on its own");
endmodule // ldc_regs_chk

bind ldc_regs ldc_regs_chk chk_u (
   .clk(clk), .rst(rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .disable_pin(disable_pin), .fault_event(fault_event),
   .settings(settings), .mode(mode), .fault_latched(fault_latched),
   .write_strobe(write_strobe)
);
`default_nettype wire

/* test/ldc_bus_master.sv */
// Behavioural two-wire bus master facing the register bank
`timescale 1ns/100ps
`default_nettype none
module ldc_bus_master (
   // Clock
   input  wire logic  clk,
   // Serial wire; a released data line floats high
   output logic       scl,
   output logic       sda_rel,
   input  wire logic  sda_wire,
   // Read result
   output logic       rd_done,
   output logic [7:0] rd_byte
);
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
      rd_done = 1'b0;
      rd_byte = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Data moves only while the clock is low; each phase lasts several cycles
   task automatic bit_xfer(input logic v, output logic s);
      sda_rel <= v;
      tick(2);
      scl <= 1'b1;
      tick(3);
      s = sda_wire;
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(b[i], s);
      end
      bit_xfer(1'b1, ack);
   endtask
   // Start, address with direction, register address, one data byte, stop
   task automatic access(input logic rd, input logic [6:0] dev, input logic [7:0] ra,
                         input logic [7:0] wd, output logic [2:0] acks);
      logic [7:0] v;
      logic       s;
      sda_rel <= 1'b0;
      tick(3);
      scl <= 1'b0;
      tick(3);
      send_byte({dev, rd}, acks[2]);
      send_byte(ra, acks[1]);
      acks[0] = 1'b0;
      if (rd) begin
         for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, v[i]);
         end
         bit_xfer(1'b1, s);
         rd_byte <= v;
         rd_done <= 1'b1;
         tick(1);
         rd_done <= 1'b0;
      end else begin
         send_byte(wd, acks[0]);
      end
      sda_rel <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(3);
      sda_rel <= 1'b1;
      tick(3);
   endtask
endmodule // ldc_bus_master
`default_nettype wire

/* test/test_laser_driver_control_regs.sv */
// Self-checking bench for the laser driver control register bank
`timescale 1ns/100ps
`default_nettype none
module test_laser_driver_control_regs;
   import ldc_pkg::*;
   logic          clk;
   logic          rst;
   logic          ce;
   logic          disable_pin;
   logic          fault_event;
   logic          scl;
   logic          sda_rel;
   logic          sda_out;
   logic          sda_oe;
   logic          rd_done;
   logic [7:0]    rd_byte;
   logic          fault_latched;
   logic          write_strobe;
   ldc_settings_t settings;
   ldc_mode_t     mode;
   wire logic     sda_wire;
   int            err_count;
   int            n_compared;
   int            seed;
   logic [7:0]    exp_q[$];
   logic [7:0]    shadow[11];
   logic [7:0]    mask[11];
   logic [2:0]    acks;
   // Pull-up on the data line; only a pulled-low driver wins
   assign sda_wire = sda_rel & ~(sda_oe & ~sda_out);
   ldc_regs dut_u (
      .clk(clk), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe(sda_oe), .disable_pin(disable_pin), .fault_event(fault_event),
      .settings(settings), .mode(mode), .fault_latched(fault_latched),
      .write_strobe(write_strobe)
   );
   ldc_bus_master m_u (
      .clk(clk), .scl(scl), .sda_rel(sda_rel), .sda_wire(sda_wire), .rd_done(rd_done),
      .rd_byte(rd_byte)
   );
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("mismatches %0d compared %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic ldc_settings_t exp_set();
      return {shadow[3], shadow[2][1:0], shadow[5], shadow[4][1:0], shadow[6], shadow[7],
              shadow[8][3:0], shadow[9][0], shadow[1][1:0]};
   endfunction
   function automatic ldc_mode_t exp_mode();
      ldc_mode_t e;
      e.chip_active = shadow[0][7] & ~disable_pin;
      e.open_loop_select = shadow[0][4];
      e.output_swap = shadow[0][2];
      e.equalizer_on = shadow[0][1];
      e.photodiode_orientation = shadow[0][0];
      e.offset_cancel_on = ~shadow[1][3];
      e.crossing_adjust_on = shadow[1][3];
      e.bias_source = shadow[1][2];
      e.bias_sink = ~shadow[1][2];
      e.fault_detect_live = shadow[0][3];
      e.photodiode_range = shadow[0][6] ? LDC_PD_LARGE : shadow[0][5] ? LDC_PD_MID : LDC_PD_SMALL;
      return e;
   endfunction
   task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
      m_u.access(1'b0, LDC_SLAVE_ADDR, ra, wd, acks);
      check(acks, 3'b000);
      shadow[ra[3:0]] = wd & mask[ra[3:0]];
      check(settings, exp_set());
      check(mode, exp_mode());
   endtask
   // The expected byte is queued before the master starts the read
   task automatic rd(input logic [7:0] ra);
      exp_q.push_back(shadow[ra[3:0]]);
      m_u.access(1'b1, LDC_SLAVE_ADDR, ra, 8'h00, acks);
      check(acks[2:1], 2'b00);
   endtask
   task automatic pulse_fault;
      fault_event <= 1'b1;
      @(posedge clk);
      fault_event <= 1'b0;
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      if (rd_done === 1'b1) begin
         if (exp_q.size() == 0)
            check(1'b1, 1'b0);
         else
            check(rd_byte, exp_q.pop_front());
      end
   end
   initial begin
      repeat (80000) @(posedge clk);
      err_count++;
      results;
   end
   initial begin
      seed = 27;
      err_count = 0;
      n_compared = 0;
      mask = '{8'hFF, 8'h0F, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h01, 8'h00};
      shadow = '{default: 8'h00};
      rst = 1'b1;
      ce = 1'b1;
      disable_pin = 1'b0;
      fault_event = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      check(settings, exp_set());
      check(mode, exp_mode());
      for (int r = 0; r < 11; r++) rd(8'(r));
      // All ones, random, then all zeros; unused bits and the unmapped place stay zero
      for (int p = 0; p < 3; p++) begin
         for (int r = 0; r < 11; r++) begin
            wr(8'(r), (p == 0) ? 8'hFF : (p == 1) ? 8'($random(seed)) : 8'h00);
            rd(8'(r));
         end
      end
      for (int i = 0; i < 8; i++) wr(8'h00, 8'h01 << i);
      for (int i = 0; i < 4; i++) wr(8'h00, {1'b1, 2'(i), 5'h00});
      for (int i = 0; i < 16; i++) wr(8'h01, 8'(i));
      m_u.access(1'b0, LDC_SLAVE_ADDR ^ 7'h01, 8'h05, 8'hA5, acks);
      check(acks, 3'b111);
      rd(8'h05);
      wr(8'h06, 8'h5A);
      wr(8'h00, 8'h80);
      disable_pin <= 1'b1;
      repeat (2) @(posedge clk);
      check(mode, exp_mode());
      rd(8'h06);
      disable_pin <= 1'b0;
      repeat (2) @(posedge clk);
      check(mode, exp_mode());
      pulse_fault;
      check(fault_latched, 1'b0);
      wr(8'h00, 8'h88);
      pulse_fault;
      check(fault_latched, 1'b1);
      wr(8'h00, 8'h08);
      check(fault_latched, 1'b1);
      wr(8'h00, 8'h88);
      check(fault_latched, 1'b0);
      // Clock enable low freezes the latch even with detection on
      ce <= 1'b0;
      pulse_fault;
      check(fault_latched, 1'b0);
      ce <= 1'b1;
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      shadow = '{default: 8'h00};
      repeat (2) @(posedge clk);
      check(settings, exp_set());
      rd(8'h00);
      check(exp_q.size(), 0);
      results;
   end
endmodule // test_laser_driver_control_regs
`default_nettype wire
